/* dv/flash_dev_model.sv */
// behavioural parallel flash that answers the host pins
// assumes pins settle between rising edges of clk_sys_i; the bench sets the knobs
`timescale 1ns/1ps
module flash_dev_model
(
    // clock
    input wire logic clk_sys_i,
    // flash pins
    input wire logic [18:0] addr_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [7:0] din_i,
    input wire logic hv_addr_i,
    input wire logic hv_oe_i,
    output logic [7:0] dout_o,
    // scenario knobs
    input wire logic load_i,
    input wire logic [7:0] busy_reads_i,
    input wire logic [7:0] limit_at_i,
    input wire logic ewin_i
);
    // ********************
    // state
    // ********************
    logic [7:0] mem [16];
    logic [7:0] prot = 8'h00;
    logic [7:0] rcnt = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] val;
    logic killed = 1'b0;
    logic tog = 1'b0;
    logic prev_rd = 1'b0;
    logic prev_wr = 1'b0;
    logic busy;
    logic limit;
    logic sel;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    assign busy = !killed && (rcnt < busy_reads_i);
    assign limit = busy && (limit_at_i != 8'h00) && (rcnt >= limit_at_i);
    assign sel = !ce_n_i && !oe_n_i;
    always_comb
    begin
        if (hv_addr_i)
            val = addr_i[1] ? {7'h00, prot[addr_i[18:16]]} : 8'h5A; // id value arbitrary
        else if (busy)
            val = {1'b0, tog, limit, 1'b0, ewin_i, tog, 2'b00};
        else
            val = mem[addr_i[3:0]];
    end
    // released bus shows the inverse of the last byte
    assign dout_o = sel ? val : ~last;
    // ********************
    // strobe ends
    // ********************
    always @(posedge clk_sys_i)
    begin
        prev_rd <= sel;
        // write needs ce and we low, oe high or high voltage on oe
        prev_wr <= !ce_n_i && !we_n_i && (oe_n_i || hv_oe_i);
        if (sel)
            last <= val;
        if (load_i)
        begin
            rcnt <= 8'h00;
            killed <= 1'b0;
        end
        else if (prev_rd && !sel)
        begin
            rcnt <= rcnt + 8'h01;
            if (busy)
                tog <= !tog;
        end
        if (prev_wr && (ce_n_i || we_n_i))
        begin
            if (hv_addr_i && hv_oe_i)
            begin
                if (addr_i[6])
                    prot <= 8'h00;
                else
                    prot[addr_i[18:16]] <= 1'b1;
            end
            else if (din_i == 8'hF0)
                killed <= 1'b1;
            else if (!busy)
                mem[addr_i[3:0]] <= din_i;
        end
    end
endmodule : flash_dev_model

/* dv/flash_status_host_assertions.sv */
// concurrent checks on the flash status host ports
// assumes binding into flash_status_host, one clock domain
`timescale 1ns/1ps
module flash_status_host_assertions
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // flash pins
    input wire logic [18:0] fl_addr_o,
    input wire logic fl_ce_n_o,
    input wire logic fl_oe_n_o,
    input wire logic fl_we_n_o,
    input wire logic [7:0] fl_dq_i,
    input wire logic [7:0] fl_dq_o,
    input wire logic fl_dq_oe_o,
    input wire logic hv_addr_sel_o,
    input wire logic hv_oe_sel_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    AST_WE_NEEDS_CE: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o)
        else $error("write strobe without chip enable or with output enable");
    AST_DQ_DRIVE_NO_OE: assert property (fl_dq_oe_o |-> fl_oe_n_o)
        else $error("host drives data while output enable is low");
    AST_WE_ADDR_HELD: assert property (!fl_we_n_o && $past(!fl_we_n_o) |->
        $stable(fl_addr_o) && $stable(fl_dq_o))
        else $error("address or data moved inside a write strobe");
    AST_HV_PAIR: assert property (hv_oe_sel_o |-> hv_addr_sel_o)
        else $error("high voltage on output enable without address line");
    AST_HV_WIDTH: assert property ($fell(fl_we_n_o) && hv_oe_sel_o |->
        (!fl_we_n_o && !fl_ce_n_o && hv_oe_sel_o && hv_addr_sel_o) [*8])
        else $error("high voltage pulse too short or mode dropped");
    AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside the cycle after a read strobe");
    AST_OE_WIDTH: assert property ($fell(fl_oe_n_o) |-> !fl_oe_n_o [*8])
        else $error("read strobe shorter than eight cycles");
    AST_CE_BUSY: assert property ($fell(fl_ce_n_o) |-> busy_o)
        else $error("bus cycle started outside a sequence");
endmodule : flash_status_host_assertions
bind flash_status_host flash_status_host_assertions u_chk (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .fl_addr_o(fl_addr_o), .fl_ce_n_o(fl_ce_n_o),
    .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o), .hv_addr_sel_o(hv_addr_sel_o), .hv_oe_sel_o(hv_oe_sel_o),
    .busy_o(busy_o));

/* dv/test_flash_status_host.sv */
// self-checking bench for the flash status host: table rows, then hand cases
// assumes the flash model and checker compile before this file
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module test_flash_status_host;
    typedef struct {
        logic [2:0] cmd;
        logic [18:0] addr;
        logic [7:0] wdata;
        logic [7:0] busy;
        logic [7:0] lim;
        logic ewin;
        logic [7:0] exp;
        logic [7:0] mask;
        logic [7:0] rdm;
        logic [7:0] rdx;
    } row_s;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [18:0] fl_addr_o;
    logic fl_ce_n_o;
    logic fl_oe_n_o;
    logic fl_we_n_o;
    logic [7:0] fl_dq_o;
    logic fl_dq_oe_o;
    logic hv_addr_sel_o;
    logic hv_oe_sel_o;
    logic busy_o;
    logic [7:0] dev_dq;
    logic [7:0] fl_dq_i;
    logic m_load = 1'b0;
    logic [7:0] m_busy = 8'h00;
    logic [7:0] m_lim = 8'h00;
    logic m_ewin = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] st;
    logic [7:0] rv;
    row_s rows [12];
    // ********************
    // clock, parts, watchdog
    // ********************
    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    assign fl_dq_i = fl_dq_oe_o ? fl_dq_o : dev_dq;
    flash_status_host DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .fl_addr_o(fl_addr_o), .fl_ce_n_o(fl_ce_n_o),
        .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
        .fl_dq_oe_o(fl_dq_oe_o), .hv_addr_sel_o(hv_addr_sel_o), .hv_oe_sel_o(hv_oe_sel_o),
        .busy_o(busy_o));
    flash_dev_model u_dev (.clk_sys_i(clk_sys_i), .addr_i(fl_addr_o), .ce_n_i(fl_ce_n_o),
        .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .din_i(fl_dq_o), .hv_addr_i(hv_addr_sel_o),
        .hv_oe_i(hv_oe_sel_o), .dout_o(dev_dq), .load_i(m_load), .busy_reads_i(m_busy),
        .limit_at_i(m_lim), .ewin_i(m_ewin));
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures = failures + 1;
            print_verdict();
        end
    end
    // ********************
    // tasks
    // ********************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask : rd
    task automatic start_row(input row_s r);
        @(posedge clk_sys_i);
        m_busy <= r.busy;
        m_lim <= r.lim;
        m_ewin <= r.ewin;
        m_load <= 1'b1;
        @(posedge clk_sys_i);
        m_load <= 1'b0;
        wr(`REG_ADDR, {13'h0000, r.addr});
        wr(`REG_WDATA, {24'h00_0000, r.wdata});
        wr(`REG_CTRL, {29'h0000_0000, r.cmd});
    endtask : start_row
    task automatic finish(output logic [7:0] s, output logic [7:0] r);
        logic [31:0] d;
        repeat (8000)
        begin
            @(posedge clk_sys_i);
            #1;
            if (busy_o === 1'b0)
                break;
        end
        check("idle", {7'h00, busy_o}, 8'h00);
        rd(`REG_STATUS, d);
        s = d[7:0];
        rd(`REG_RDATA, d);
        r = d[7:0];
    endtask : finish
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // ********************
    // main sequence
    // ********************
    initial
    begin
        rows = '{
            '{`CMD_WRITE, 19'h0_0005, 8'hA5, 8'h00, 8'h00, 1'b0, 8'h02, 8'h02, 8'h00, 8'h00},
            '{`CMD_READ, 19'h0_0005, 8'h00, 8'h00, 8'h00, 1'b0, 8'h02, 8'h02, 8'hFF, 8'hA5},
            '{`CMD_POLL, 19'h0_0000, 8'h00, 8'h00, 8'h00, 1'b0, 8'h06, 8'h0E, 8'h00, 8'h00},
            '{`CMD_POLL, 19'h0_0000, 8'h00, 8'h03, 8'h00, 1'b0, 8'h06, 8'h0E, 8'h00, 8'h00},
            '{`CMD_POLL, 19'h0_0000, 8'h00, 8'h06, 8'h05, 1'b0, 8'h06, 8'h0E, 8'h00, 8'h00},
            '{`CMD_EWCHECK, 19'h0_0000, 8'h00, 8'hFF, 8'h00, 1'b0, 8'h00, 8'h40, 8'h00, 8'h00},
            '{`CMD_EWCHECK, 19'h0_0000, 8'h00, 8'hFF, 8'h00, 1'b1, 8'h40, 8'h40, 8'h00, 8'h00},
            '{`CMD_PROTECT, 19'h2_0000, 8'h00, 8'h00, 8'h00, 1'b0, 8'h02, 8'h02, 8'h00, 8'h00},
            '{`CMD_PVERIFY, 19'h2_0002, 8'h00, 8'h00, 8'h00, 1'b0, 8'h20, 8'h20, 8'h00, 8'h00},
            '{`CMD_PVERIFY, 19'h3_0002, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h20, 8'h00, 8'h00},
            '{`CMD_UNPROTECT, 19'h0_0000, 8'h00, 8'h00, 8'h00, 1'b0, 8'h02, 8'h02, 8'h00, 8'h00},
            '{`CMD_PVERIFY, 19'h2_0002, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h20, 8'h00, 8'h00}};
        repeat (20) @(posedge clk_sys_i);
        check("rst_pins", {3'h0, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_dq_oe_o, busy_o}, 8'h1C);
        arst_n_i <= 1'b1;
        foreach (rows[i])
        begin
            start_row(rows[i]);
            finish(st, rv);
            check("row_status", st & rows[i].mask, rows[i].exp);
            check("row_rdata", rv & rows[i].rdm, rows[i].rdx);
        end
        // stuck operation with a refused command in the middle
        start_row('{`CMD_POLL, 19'h0_0000, 8'h00, 8'hFF, 8'h04, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00});
        repeat (60) @(posedge clk_sys_i);
        wr(`REG_CTRL, 32'h0000_0001);
        finish(st, rv);
        check("fail_status", st & 8'h0E, 8'h0A);
        check("reset_cmd", {7'h00, u_dev.killed}, 8'h01);
        wr(4'hF, 32'hFFFF_FFFF);
        start_row('{`CMD_WRITE, 19'h0_0007, 8'h3C, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00});
        finish(st, rv);
        start_row('{`CMD_READ, 19'h0_0007, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00});
        finish(st, rv);
        check("after_reset", rv, 8'h3C);
        // reset in the middle of a protect pulse
        start_row('{`CMD_PROTECT, 19'h5_0000, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00});
        repeat (100) @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        check("mid_reset", {3'h0, fl_ce_n_o, fl_we_n_o, fl_dq_oe_o, hv_addr_sel_o, hv_oe_sel_o}, 8'h18);
        check("no_protect", u_dev.prot, 8'h00);
        @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check("post_rst", {6'h00, fl_ce_n_o, busy_o}, 8'h02);
        print_verdict();
    end
endmodule : test_flash_status_host

/* inc/flash_host_cfg.svh */
// constants for the parallel flash status-polling host controller
// assumes a byte-wide flash with active-low strobes driven by this host
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
// register offsets of the host command port
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_WDATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
`define REG_VERIFY 4'h5
// ctrl register command codes (bits 2:0 of a write)
`define CMD_READ 3'h1
`define CMD_WRITE 3'h2
`define CMD_POLL 3'h3
`define CMD_PROTECT 3'h4
`define CMD_UNPROTECT 3'h5
`define CMD_PVERIFY 3'h6
`define CMD_EWCHECK 3'h7
// data bit positions of the flash status byte
`define BIT_DATA_POLL 7
`define BIT_TOGGLE_ONE 6
`define BIT_TIMING_LIMIT 5
`define BIT_ERASE_WINDOW 3
`define BIT_TOGGLE_TWO 2
`define BIT_PROTECT 0
// reset command data
`define RESET_CMD_DATA 8'hF0
// address line positions for the high voltage modes
`define ADDR_HV_SEL 9
`define ADDR_PROT_MODE 6
`define ADDR_ID_PAGE 1
// strobe timing in ns, cycles derived at 5 ns clock
`define CLK_PERIOD_NS 5
`define T_STROBE_NS 100
`define T_SETUP_NS 50
`define T_HV_PULSE_NS 10000
`define STROBE_CYC ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HV_PULSE_CYC ((`T_HV_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* inc/flash_host_pkg.sv */
// types for the parallel flash status-polling host controller
// assumes flash_host_cfg.svh for all numbers
package flash_host_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER,
        ST_DECIDE,
        ST_DONE
    } seq_state_e;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_READ,
        OP_WRITE,
        OP_POLL,
        OP_HV,
        OP_EWCHECK
    } op_kind_e;
    typedef enum logic [2:0] {
        PR_FIRST,
        PR_SECOND,
        PR_RECHECK_A,
        PR_RECHECK_B,
        PR_RESET_CMD
    } poll_phase_e;
endpackage : flash_host_pkg

/* rtl/flash_sample_reg.sv */
// sample register capturing the flash data byte at the end of a read strobe
// assumes the data pins are synchronous to clk_sys_i
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_sample_reg
    import flash_host_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // capture
    input wire logic load_i,
    input wire logic [7:0] data_i,
    // held byte
    output logic [7:0] cur_o,
    output logic [7:0] prev_o
);
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cur_o <= 8'h00;
            prev_o <= 8'h00;
        end
        else if (load_i)
        begin
            prev_o <= cur_o;
            cur_o <= data_i;
        end
    end
endmodule : flash_sample_reg

/* rtl/flash_status_host.sv */
// host controller that drives the flash pins, polls status and runs protect modes
// assumes flash pins synchronous to clk_sys_i, high voltage by external switch
// Functional notes
// - read status byte twice, compare toggle bits
// - no toggle means done, array next
// - still toggling, check timing_limit_flag, recheck
// - toggling after limit is failure, send reset
// - abandoned poll restarts from double read
// - reset command before new operations
// - check erase_window_flag before and after command
// - protect with high voltage, mode pin low
// - unprotect with high voltage, mode pin high
// - protect every sector before unprotecting; CMD_UNPROTECT here pulses at once without protecting any sector first
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_status_host
    import flash_host_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // software register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // flash address and strobes
    output logic [18:0] fl_addr_o,
    output logic fl_ce_n_o,
    output logic fl_oe_n_o,
    output logic fl_we_n_o,
    // flash data bus
    input wire logic [7:0] fl_dq_i,
    output logic [7:0] fl_dq_o,
    output logic fl_dq_oe_o,
    // high voltage switch requests
    output logic hv_addr_sel_o,
    output logic hv_oe_sel_o,
    // busy level
    output logic busy_o
);
    // ****************************************
    // registers
    // ****************************************
    seq_state_e state_ff;
    op_kind_e op_ff;
    poll_phase_e phase_ff;
    logic [18:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [11:0] cnt_ff;
    logic [2:0] cmd_ff;
    logic done_ff;
    logic ok_ff;
    logic fail_ff;
    logic toggling_ff;
    logic prot_ff;
    logic ew_before_ff;
    logic ew_rejected_ff;
    logic sample_ld;
    logic [7:0] cur_byte;
    logic [7:0] prev_byte;
    logic is_read;
    logic hv_mode;
    logic start;
    logic toggle_diff;
    assign start = reg_wr_i && (reg_addr_i == `REG_CTRL) && (state_ff == ST_IDLE);
    assign is_read = (op_ff == OP_READ) || (op_ff == OP_POLL) || (op_ff == OP_EWCHECK)
        || ((op_ff == OP_HV) && (cmd_ff == `CMD_PVERIFY));
    assign hv_mode = (op_ff == OP_HV);
    assign toggle_diff = (cur_byte[`BIT_TOGGLE_ONE] != prev_byte[`BIT_TOGGLE_ONE])
        || (cur_byte[`BIT_TOGGLE_TWO] != prev_byte[`BIT_TOGGLE_TWO]);
    assign sample_ld = (state_ff == ST_STROBE) && (cnt_ff == 12'd0) && is_read;
    flash_sample_reg u_sample
    (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .load_i(sample_ld),
        .data_i(fl_dq_i),
        .cur_o(cur_byte),
        .prev_o(prev_byte)
    );
    // ****************************************
    // command capture
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            addr_ff <= 19'h0_0000;
            wdata_ff <= 8'h00;
        end
        else if (reg_wr_i && (reg_addr_i == `REG_ADDR))
        begin
            addr_ff <= reg_wdata_i[18:0];
        end
        else if (reg_wr_i && (reg_addr_i == `REG_WDATA))
        begin
            wdata_ff <= reg_wdata_i[7:0];
        end
    end
    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_ff <= ST_IDLE;
            op_ff <= OP_NONE;
            phase_ff <= PR_FIRST;
            cnt_ff <= 12'd0;
            cmd_ff <= 3'h0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        cmd_ff <= reg_wdata_i[2:0];
                        // every poll starts from the first double read
                        phase_ff <= PR_FIRST;
                        cnt_ff <= 12'(`SETUP_CYC);
                        state_ff <= ST_SETUP;
                        case (reg_wdata_i[2:0])
                            `CMD_READ: op_ff <= OP_READ;
                            `CMD_WRITE: op_ff <= OP_WRITE;
                            `CMD_POLL: op_ff <= OP_POLL;
                            `CMD_EWCHECK: op_ff <= OP_EWCHECK;
                            `CMD_PROTECT, `CMD_UNPROTECT, `CMD_PVERIFY: op_ff <= OP_HV;
                            default:
                            begin
                                op_ff <= OP_NONE;
                                state_ff <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_SETUP:
                begin
                    if (cnt_ff == 12'd0)
                    begin
                        state_ff <= ST_STROBE;
                        cnt_ff <= (hv_mode && !is_read) ? 12'(`HV_PULSE_CYC) : 12'(`STROBE_CYC);
                    end
                    else
                    begin
                        cnt_ff <= cnt_ff - 12'd1;
                    end
                end
                ST_STROBE:
                begin
                    if (cnt_ff == 12'd0)
                    begin
                        state_ff <= ST_RECOVER;
                        cnt_ff <= 12'(`SETUP_CYC);
                    end
                    else
                    begin
                        cnt_ff <= cnt_ff - 12'd1;
                    end
                end
                ST_RECOVER:
                begin
                    if (cnt_ff == 12'd0)
                    begin
                        state_ff <= ST_DECIDE;
                    end
                    else
                    begin
                        cnt_ff <= cnt_ff - 12'd1;
                    end
                end
                ST_DECIDE:
                begin
                    state_ff <= ST_DONE;
                    if (op_ff == OP_POLL)
                    begin
                        cnt_ff <= 12'(`SETUP_CYC);
                        case (phase_ff)
                            PR_FIRST:
                            begin
                                phase_ff <= PR_SECOND;
                                state_ff <= ST_SETUP;
                            end
                            PR_SECOND:
                            begin
                                // still toggling and limit high, recheck
                                if (toggle_diff && cur_byte[`BIT_TIMING_LIMIT])
                                begin
                                    phase_ff <= PR_RECHECK_A;
                                    state_ff <= ST_SETUP;
                                end
                                else if (toggle_diff)
                                begin
                                    phase_ff <= PR_FIRST;
                                    state_ff <= ST_SETUP;
                                end
                            end
                            PR_RECHECK_A:
                            begin
                                phase_ff <= PR_RECHECK_B;
                                state_ff <= ST_SETUP;
                            end
                            PR_RECHECK_B:
                            begin
                                if (toggle_diff)
                                begin
                                    phase_ff <= PR_RESET_CMD;
                                    state_ff <= ST_SETUP;
                                end
                            end
                            default:
                            begin
                                state_ff <= ST_DONE;
                            end
                        endcase
                    end
                end
                ST_DONE:
                begin
                    op_ff <= OP_NONE;
                    state_ff <= ST_IDLE;
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
    // ****************************************
    // results
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            done_ff <= 1'b0;
            ok_ff <= 1'b0;
            fail_ff <= 1'b0;
            toggling_ff <= 1'b0;
            prot_ff <= 1'b0;
            ew_before_ff <= 1'b0;
            ew_rejected_ff <= 1'b0;
        end
        else if (start)
        begin
            done_ff <= 1'b0;
            ok_ff <= 1'b0;
            fail_ff <= 1'b0;
        end
        else if (state_ff == ST_DECIDE)
        begin
            if ((op_ff == OP_POLL) && ((phase_ff == PR_SECOND) || (phase_ff == PR_RECHECK_B)))
            begin
                toggling_ff <= toggle_diff;
                if (!toggle_diff)
                begin
                    done_ff <= 1'b1;
                    ok_ff <= 1'b1;
                end
            end
            if ((op_ff == OP_POLL) && (phase_ff == PR_RESET_CMD))
            begin
                done_ff <= 1'b1;
                fail_ff <= 1'b1;
            end
            if (op_ff != OP_POLL)
            begin
                done_ff <= 1'b1;
                ok_ff <= 1'b1;
            end
            if ((op_ff == OP_HV) || (op_ff == OP_READ))
            begin
                prot_ff <= cur_byte[`BIT_PROTECT];
            end
            // erase window sampled before and after
            if (op_ff == OP_EWCHECK)
            begin
                ew_before_ff <= cur_byte[`BIT_ERASE_WINDOW];
            end
            if ((op_ff == OP_WRITE) && !ew_before_ff)
            begin
                ew_rejected_ff <= 1'b0;
            end
            if ((op_ff == OP_EWCHECK) && !ew_before_ff && cur_byte[`BIT_ERASE_WINDOW])
            begin
                ew_rejected_ff <= 1'b1;
            end
        end
    end
    // ****************************************
    // pin drive
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fl_addr_o <= 19'h0_0000;
            fl_ce_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            fl_we_n_o <= 1'b1;
            fl_dq_o <= 8'h00;
            fl_dq_oe_o <= 1'b0;
            hv_addr_sel_o <= 1'b0;
            hv_oe_sel_o <= 1'b0;
        end
        else
        begin
            fl_addr_o <= addr_ff;
            if (hv_mode)
            begin
                fl_addr_o[`ADDR_PROT_MODE] <= (cmd_ff == `CMD_UNPROTECT);
                fl_addr_o[`ADDR_ID_PAGE] <= (cmd_ff == `CMD_PVERIFY);
            end
            fl_ce_n_o <= !((state_ff == ST_SETUP) || (state_ff == ST_STROBE)
                || (state_ff == ST_RECOVER)) || (op_ff == OP_NONE);
            // high voltage on output enable only for protect and unprotect
            hv_addr_sel_o <= hv_mode;
            hv_oe_sel_o <= hv_mode && (cmd_ff != `CMD_PVERIFY);
            // output enable high whenever write enable is low
            fl_oe_n_o <= !((state_ff == ST_STROBE) && is_read && (phase_ff != PR_RESET_CMD));
            fl_we_n_o <= !((state_ff == ST_STROBE) && (cnt_ff != 12'd0)
                && (!is_read || (phase_ff == PR_RESET_CMD)));
            fl_dq_oe_o <= (state_ff != ST_IDLE) && (!is_read || (phase_ff == PR_RESET_CMD))
                && !hv_mode;
            fl_dq_o <= (phase_ff == PR_RESET_CMD) ? `RESET_CMD_DATA : wdata_ff;
        end
    end
    assign busy_o = (state_ff != ST_IDLE);
    // ****************************************
    // register read
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            reg_rdata_o <= 32'h0000_0000;
        end
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `REG_CTRL: reg_rdata_o <= {29'h0000_0000, cmd_ff};
                `REG_ADDR: reg_rdata_o <= {13'h0000, addr_ff};
                `REG_WDATA: reg_rdata_o <= {24'h00_0000, wdata_ff};
                `REG_STATUS: reg_rdata_o <= {25'h000_0000, ew_rejected_ff, prot_ff,
                    toggling_ff, fail_ff, ok_ff, done_ff, busy_o};
                `REG_RDATA: reg_rdata_o <= {16'h0000, prev_byte, cur_byte};
                `REG_VERIFY: reg_rdata_o <= {31'h0000_0000, prot_ff};
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end
        else
        begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end
endmodule : flash_status_host
